// ### hw/gstm_timer.sv
// Gated sixteen-bit timer/counter with an AHB-Lite register port.
// Assumes one 125 MHz system clock; the instruction clock is a quarter of it.
// External clocks, crystal and gate arrive asynchronously and are synchronised.
//
// Functional notes
// RULE1: Sixteen-bit up-counter in two byte registers; byte writes replace count bits at once.
// RULE2: Off bit stops counting; gate enable restricts counting to gate-permitted time.
// RULE3: Instruction clock source advances the count once per instruction cycle through prescaler.
// RULE4: External sources count rising edges, synchronised or asynchronous.
// RULE5: Source field: 11 capsense, 10 pin or crystal, 01 system, 00 instruction.
// RULE6: System clock source adds four per instruction cycle.
// RULE7: External counting needs a falling edge after enable, byte write or disable.
// RULE8: Two-bit prescale field divides the selected clock by 1, 2, 4 or 8.
// RULE9: Prescale counter is hidden and cleared by any count byte write.
// RULE10: Oscillator enable starts the crystal amplifier, which keeps running in sleep.
// RULE11: Software waits for crystal start-up using a preset count and the overflow flag.
// RULE12: Bypass bit feeds external edges straight to the counter, not phase aligned.
// RULE13: Asynchronous external counting continues in sleep and overflow raises the wake interrupt.
// RULE14: Switching sync mode may drop or add one count.
// RULE15: Byte reads are not coherent; software handles overflow between byte reads.
// RULE16: Software stops the timer before writing count bytes.
// RULE17: Rollover from all ones sets the sticky overflow flag.
// RULE18: Gate enabled with inactive gate level holds the count.
// RULE19: While off, count and prescaler hold and no overflow occurs.
`timescale 1ns/1ps

module gstm_timer (
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [gstm_pkg::DATA_W-1:0]  hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic      [gstm_pkg::DATA_W-1:0]  hrdata,
  input  wire logic                         external_clock_pin,
  input  wire logic                         capsense_osc_clock,
  input  wire logic                         crystal_in_pin,
  input  wire logic                         gate_in,
  input  wire logic                         sleep_mode,
  output logic                              crystal_out_pin,
  output logic                              irq
);
  import gstm_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [IN_N-1:0]    s1_q, s2_q, s3_q, filt_q, filt_d, async_in;
  gstm_ctrl_s         ctrl_q, ctrl_d;
  gstm_gate_s         gate_q, gate_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic [PRE_W-1:0]   pre_q, pre_d, pmask;
  logic [1:0]         div_q;
  logic               prv_q, armed_q, armed_d, pend_q, pend_d;
  logic               stat_q, stat_d, mask_q, mask_d;
  logic               wr_q, hready_q, hresp_q, irq_q, xout_q;
  logic [OFF_W-1:0]   waddr_q;
  logic [DATA_W-1:0]  rdata_q, rd_val;
  logic               acc, rd, wr_ctrl, wr_gate, wr_low, wr_high, wr_mask, cnt_wr;
  logic               ext_lvl, rise, fall, is_ext, gate_ok, run, awake, insn_en;
  logic               ext_edge, src_tick, tick, inc, ovf, stat_clr;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  // Asynchronous inputs gathered into one bank.
  assign async_in[IN_PIN]  = external_clock_pin;
  assign async_in[IN_CAP]  = capsense_osc_clock;
  assign async_in[IN_XTAL] = crystal_in_pin;
  assign async_in[IN_GATE] = gate_in;

  // The filtered level follows only when the second and third stages agree.
  assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));

  // Three-stage chain; the first stage feeds only the second.
  always_ff @(posedge clk) begin
    s1_q <= async_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (!resetn) begin
      filt_q <= '0;
    end else begin
      filt_q <= filt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register port decode.

  // An address phase is taken when selected, ready and active.
  assign acc     = hsel && hready && htrans[HTRANS_ACT];
  assign rd      = acc && !hwrite;
  assign wr_ctrl = wr_q && reg_hit(waddr_q, OFF_CTRL);
  assign wr_gate = wr_q && reg_hit(waddr_q, OFF_GATE);
  assign wr_low  = wr_q && reg_hit(waddr_q, OFF_LOW);
  assign wr_high = wr_q && reg_hit(waddr_q, OFF_HIGH);
  assign wr_mask = wr_q && reg_hit(waddr_q, OFF_MASK);
  assign cnt_wr  = wr_low || wr_high;
  assign stat_clr = rd && reg_hit(haddr[OFF_W-1:0], OFF_STAT);

  // Next values of the software-visible control words.
  assign ctrl_d = wr_ctrl ? gstm_ctrl_s'(hwdata[6:0]) : ctrl_q;
  assign gate_d = wr_gate ? gstm_gate_s'(hwdata[1:0]) : gate_q;
  assign mask_d = wr_mask ? hwdata[0] : mask_q;

  //////////////////////////////////////////////////////////////////////////
  // Clock source selection and edge detection.

  // Source 10 picks the crystal when its amplifier is enabled, else the pin.
  assign is_ext  = ctrl_q.src[1]; // RULE5
  assign ext_lvl = (ctrl_q.src == SRC_CAP) ? filt_q[IN_CAP] :
                   ctrl_q.osc_en ? filt_q[IN_XTAL] : filt_q[IN_PIN]; // RULE5
  assign rise    = ext_lvl && !prv_q;
  assign fall    = !ext_lvl && prv_q;

  // Counting is allowed by the on bit and, if enabled, the gate level.
  assign gate_ok = !gate_q.en || (filt_q[IN_GATE] == gate_q.pol); // RULE18
  assign run     = ctrl_q.on && gate_ok; // RULE2
  assign awake   = !sleep_mode;
  assign insn_en = (div_q == INSN_LAST);

  // A rising edge counts only after a falling edge was seen while on.
  assign ext_edge = is_ext && rise && armed_q; // RULE7
  assign armed_d  = (!ctrl_q.on || cnt_wr) ? 1'b0 : (armed_q || fall); // RULE7

  // Synchronous mode holds an edge until the next instruction phase.
  assign pend_d = (!ctrl_q.on || cnt_wr) ? 1'b0 :
                  ((ext_edge && !ctrl_q.byp) || (pend_q && !(insn_en && awake))); // RULE14

  // Per-source tick before the prescaler; only asynchronous edges run in sleep.
  assign src_tick = (ctrl_q.src == SRC_INSN) ? (insn_en && awake) : // RULE3
                    (ctrl_q.src == SRC_SYS)  ? awake :              // RULE6
                    ctrl_q.byp ? ext_edge :                         // RULE12 RULE13
                    (pend_q && insn_en && awake);                   // RULE4

  // A count byte write wins over a colliding increment.
  assign tick = run && src_tick && !cnt_wr; // RULE19

  //////////////////////////////////////////////////////////////////////////
  // Prescaler and counter.

  // One count passes when all selected prescale bits are set.
  assign pmask = pre_mask(ctrl_q.pre); // RULE8
  assign inc   = tick && ((pre_q & pmask) == pmask); // RULE8
  assign pre_d = cnt_wr ? PRE_RST : (tick ? pre_q + 3'h1 : pre_q); // RULE9
  assign ovf   = inc && (cnt_q == CNT_MAX); // RULE17

  // Byte writes replace their half at once; otherwise increment.
  assign cnt_d = wr_low  ? {cnt_q[CNT_W-1:BYTE_W], hwdata[BYTE_W-1:0]} : // RULE1
                 wr_high ? {hwdata[BYTE_W-1:0], cnt_q[BYTE_W-1:0]} :      // RULE1
                 inc     ? cnt_q + 16'h0001 : cnt_q;

  // Sticky overflow; a read clears it but a new event in that cycle stays.
  assign stat_d = (stat_q && !stat_clr) || ovf; // RULE17

  //////////////////////////////////////////////////////////////////////////
  // Read data.

  // Reads see next-state values, except the status flag, so a write just before is reflected.
  assign rd_val =
    reg_hit(haddr[OFF_W-1:0], OFF_CTRL) ? to_word({1'b0, ctrl_d}) :
    reg_hit(haddr[OFF_W-1:0], OFF_GATE) ? to_word({5'h00, filt_q[IN_GATE], gate_d}) :
    reg_hit(haddr[OFF_W-1:0], OFF_LOW)  ? to_word(cnt_d[BYTE_W-1:0]) : // RULE15
    reg_hit(haddr[OFF_W-1:0], OFF_HIGH) ? to_word(cnt_d[CNT_W-1:BYTE_W]) : // RULE15
    reg_hit(haddr[OFF_W-1:0], OFF_STAT) ? to_word({7'h00, stat_q}) :
    reg_hit(haddr[OFF_W-1:0], OFF_MASK) ? to_word({7'h00, mask_d}) : '0;

  //////////////////////////////////////////////////////////////////////////
  // State registers.

  // Bus-side registers: zero wait states, always OKAY.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_q     <= 1'b0;
      waddr_q  <= '0;
      rdata_q  <= '0;
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
    end else begin
      wr_q     <= acc && hwrite;
      waddr_q  <= haddr[OFF_W-1:0];
      rdata_q  <= rd ? rd_val : '0;
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
    end
  end

  // Control and interrupt registers.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RST;
      gate_q <= GATE_RST;
      mask_q <= EV_RST;
      stat_q <= EV_RST;
      irq_q  <= 1'b0;
      xout_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      gate_q <= gate_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      irq_q  <= stat_d && mask_d; // RULE13
      xout_q <= ctrl_q.osc_en && !filt_q[IN_XTAL]; // RULE10
    end
  end

  // Counting registers.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q   <= CNT_RST;
      pre_q   <= PRE_RST;
      div_q   <= 2'h0;
      prv_q   <= 1'b0;
      armed_q <= 1'b0;
      pend_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      pre_q   <= pre_d;
      div_q   <= div_q + 2'h1;
      prv_q   <= ext_lvl;
      armed_q <= armed_d;
      pend_q  <= pend_d;
    end
  end

  // Outputs straight from flip-flops.
  assign hreadyout       = hready_q;
  assign hresp           = hresp_q;
  assign hrdata          = rdata_q;
  assign irq             = irq_q;
  assign crystal_out_pin = xout_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // A low byte write lands in the count on the next edge.
  property p_low_wr;
    wr_low |=> cnt_q[BYTE_W-1:0] == $past(hwdata[BYTE_W-1:0]);
  endproperty
  a_low_wr: assert property (p_low_wr) else $error("low byte write lost"); // RULE1

  // Off and no write: the count stands still and never overflows.
  property p_off_hold;
    (!ctrl_q.on && !cnt_wr) |=> $stable(cnt_q) && !$rose(stat_q);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("count moved while off"); // RULE2 RULE19

  // Instruction source, divide by one: one step per instruction phase.
  property p_insn;
    (run && ctrl_q.src == SRC_INSN && ctrl_q.pre == 2'h0 && awake && insn_en && !cnt_wr)
      |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_insn: assert property (p_insn) else $error("instruction tick missed"); // RULE3

  // System source: four steps over four cycles.
  sequence s_sys_run;
    run && ctrl_q.src == SRC_SYS && ctrl_q.pre == 2'h0 && awake && !cnt_wr;
  endsequence
  property p_sys4;
    s_sys_run [*4] |=> cnt_q == $past(cnt_q, 4) + 16'h0004;
  endproperty
  a_sys4: assert property (p_sys4) else $error("system source not four per phase"); // RULE6

  // A held synchronous edge is applied at the instruction phase.
  property p_sync_ext;
    (pend_q && insn_en && awake && run && is_ext && !ctrl_q.byp && ctrl_q.pre == 2'h0 && !cnt_wr)
      |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_sync_ext: assert property (p_sync_ext) else $error("synchronous edge missed"); // RULE4

  // Without a prior falling edge an external source never ticks.
  property p_arm;
    (is_ext && !armed_q && !pend_q) |-> !tick;
  endproperty
  a_arm: assert property (p_arm) else $error("count before falling edge"); // RULE7

  // Divide by two lets only every other tick through.
  property p_div2;
    (tick && ctrl_q.pre == 2'h1 && !pre_q[0]) |-> !inc;
  endproperty
  a_div2: assert property (p_div2) else $error("prescale leak"); // RULE8

  // A count write clears the prescaler and the edge arming.
  property p_wr_clear;
    cnt_wr |=> pre_q == PRE_RST && !armed_q;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("write did not clear prescaler"); // RULE9

  // Asynchronous edges still count in sleep.
  property p_sleep;
    (sleep_mode && ext_edge && ctrl_q.byp && run && ctrl_q.pre == 2'h0 && !cnt_wr)
      |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep count missed"); // RULE12 RULE13

  // Rollover sets the flag, and the masked flag raises the interrupt.
  property p_ovf;
    ovf |=> stat_q && cnt_q == CNT_RST && irq == mask_q;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set"); // RULE17

  // Inactive gate level holds the count.
  property p_gate;
    (ctrl_q.on && gate_q.en && filt_q[IN_GATE] != gate_q.pol && !cnt_wr) |=> $stable(cnt_q);
  endproperty
  a_gate: assert property (p_gate) else $error("count moved with gate closed"); // RULE18

  // Crystal amplifier output stays low while disabled.
  property p_xtal;
    !ctrl_q.osc_en |=> !crystal_out_pin;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal driven while off"); // RULE10

  // A status read clears the flag unless a rollover lands in the same cycle.
  property p_stat_clr;
    (stat_clr && !ovf) |=> !stat_q;
  endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("overflow flag not cleared by read"); // RULE17

  // A set and unmasked flag keeps the wake interrupt up.
  property p_irq;
    (stat_q && mask_q && !stat_clr && !wr_mask) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing"); // RULE13

  // A high byte write lands in the count on the next edge.
  property p_high_wr;
    wr_high |=> cnt_q[CNT_W-1:BYTE_W] == $past(hwdata[BYTE_W-1:0]);
  endproperty
  a_high_wr: assert property (p_high_wr) else $error("high byte write lost"); // RULE1

  // A falling edge seen while on arms the next rising edge.
  property p_arm_fall;
    (ctrl_q.on && !cnt_wr && fall) |=> armed_q;
  endproperty
  a_arm_fall: assert property (p_arm_fall) else $error("falling edge did not arm"); // RULE7

  // While off and not written, the prescaler keeps its state.
  property p_pre_hold;
    (!ctrl_q.on && !cnt_wr) |=> $stable(pre_q);
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("prescaler moved while off"); // RULE19

endmodule : gstm_timer

// ### inc/gstm_pkg.sv
// Shared definitions for the gated sixteen-bit timer: register offsets,
// control field layouts, reset values and small decode helpers.
// Assumes a 32-bit AHB-Lite register port with word-aligned registers.
package gstm_pkg;

  // Counter and bus widths.
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned OFF_W  = 8;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned PRE_W  = 3;

  // Register byte offsets.
  localparam logic [OFF_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [OFF_W-1:0] OFF_GATE = 8'h04;
  localparam logic [OFF_W-1:0] OFF_LOW  = 8'h08;
  localparam logic [OFF_W-1:0] OFF_HIGH = 8'h0c;
  localparam logic [OFF_W-1:0] OFF_STAT = 8'h10;
  localparam logic [OFF_W-1:0] OFF_MASK = 8'h14;

  // Reset values and limits.
  localparam logic [CNT_W-1:0] CNT_RST   = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX   = 16'hffff;
  localparam logic [PRE_W-1:0] PRE_RST   = 3'h0;
  localparam logic [1:0]       INSN_LAST = 2'h3;
  localparam logic             EV_RST    = 1'b0;

  // Index of each asynchronous input in the synchroniser bank, and of the htrans active bit.
  localparam int unsigned IN_PIN  = 0;
  localparam int unsigned IN_CAP  = 1;
  localparam int unsigned IN_XTAL = 2;
  localparam int unsigned IN_GATE = 3;
  localparam int unsigned IN_N    = 4;
  localparam int unsigned HTRANS_ACT = 1;

  // Clock source codes.
  typedef enum logic [1:0] {
    SRC_INSN = 2'h0,
    SRC_SYS  = 2'h1,
    SRC_EXT  = 2'h2,
    SRC_CAP  = 2'h3
  } gstm_src_e;

  // Timer control register layout, bit 0 upward: on, source, prescale, osc, bypass.
  typedef struct packed {
    logic      byp;
    logic      osc_en;
    logic [1:0] pre;
    gstm_src_e src;
    logic      on;
  } gstm_ctrl_s;

  // Gate control register layout, bit 0 upward: enable, polarity.
  typedef struct packed {
    logic pol;
    logic en;
  } gstm_gate_s;

  localparam gstm_ctrl_s CTRL_RST = gstm_ctrl_s'(7'h00);
  localparam gstm_gate_s GATE_RST = gstm_gate_s'(2'h0);

  // Mask of prescale counter bits that must all be set for one count.
  function automatic logic [PRE_W-1:0] pre_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    pre_mask = 3'h0;
      2'h1:    pre_mask = 3'h1;
      2'h2:    pre_mask = 3'h3;
      default: pre_mask = 3'h7;
    endcase
  endfunction : pre_mask

  // True when a bus address selects the word at the given offset.
  function automatic logic reg_hit(input logic [OFF_W-1:0] a, input logic [OFF_W-1:0] off);
    reg_hit = (a[OFF_W-1:2] == off[OFF_W-1:2]);
  endfunction : reg_hit

  // Zero-extends one byte to a bus word.
  function automatic logic [DATA_W-1:0] to_word(input logic [BYTE_W-1:0] b);
    to_word = {24'h000000, b};
  endfunction : to_word

endpackage : gstm_pkg

// ### verification/gstm_ext_src.sv
// Far-side model: external count clock, capacitive-sense oscillator and a crystal.
// Assumes the timer's clk; the crystal half period is scaled to ten clocks.
`timescale 1ns/1ps

module gstm_ext_src (
  input  wire logic clk,
  input  wire logic crystal_out_pin,
  output logic      external_clock_pin,
  output logic      capsense_osc_clock,
  output logic      crystal_in_pin
);
  logic seen_q;

  // All lines idle low, as if pulled down.
  initial begin
    external_clock_pin = 1'b0;
    capsense_osc_clock = 1'b0;
    crystal_in_pin     = 1'b0;
    seen_q             = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sends n pulses, five clocks high and five low, on one source.
  task automatic pulses(input logic sel, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (5) @(posedge clk);
      if (sel) begin
        capsense_osc_clock <= 1'b1;
      end else begin
        external_clock_pin <= 1'b1;
      end
      repeat (5) @(posedge clk);
      capsense_osc_clock <= 1'b0;
      external_clock_pin <= 1'b0;
    end
  endtask : pulses

  ////////////////////////////////////////////////////////////////////////
  // The crystal only swings while the amplifier kicks it in each low half.
  always @(posedge crystal_out_pin) seen_q = 1'b1;
  always begin
    #80;
    crystal_in_pin = crystal_in_pin ? 1'b0 : seen_q;
    seen_q = 1'b0;
  end
endmodule : gstm_ext_src

// ### verification/test_gstm_timer.sv
// Self-checking bench for the gated sixteen-bit timer.
// Assumes the AHB-Lite slave answers with no wait states; the far side is gstm_ext_src.
`timescale 1ns/1ps

module test_gstm_timer;
  import gstm_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        gate_in = 1'b0;
  logic        sleep_mode = 1'b0;
  logic        hreadyout, hresp, irq, xo, ecp, ccl, xin;
  logic [31:0] hrdata;
  logic [15:0] v;
  logic [31:0] r;
  int          err_count = 0;
  int          checks = 0;
  int          cyc = 0;

  // Clock of 8 ns and the hang limit.
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end

  gstm_timer uut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .external_clock_pin(ecp), .capsense_osc_clock(ccl),
    .crystal_in_pin(xin), .gate_in(gate_in), .sleep_mode(sleep_mode), .crystal_out_pin(xo), .irq(irq));
  gstm_ext_src u_src (.clk(clk), .crystal_out_pin(xo), .external_clock_pin(ecp),
    .capsense_osc_clock(ccl), .crystal_in_pin(xin));

  ////////////////////////////////////////////////////////////////////////
  // One single AHB-Lite transfer; entered just after a rising edge.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, r);
  endtask : wr

  // Count bytes are written only while the timer is stopped.
  task automatic set_cnt(input logic [15:0] c);
    wr(OFF_LOW, {24'h000000, c[7:0]});
    wr(OFF_HIGH, {24'h000000, c[15:8]});
  endtask : set_cnt

  task automatic get_cnt(output logic [15:0] c);
    bus(OFF_LOW, 1'b0, 32'h0, r);
    c[7:0] = r[7:0];
    bus(OFF_HIGH, 1'b0, 32'h0, r);
    c[15:8] = r[7:0];
  endtask : get_cnt

  // Compare tasks: exact word and inclusive range.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    bus(OFF_CTRL, 1'b0, 32'h0, r);
    chk(r, 32'h0);
    get_cnt(v);
    chk({16'h0, v}, 32'h0);
    bus(8'h40, 1'b0, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, xo}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // Internal sources: system through every prescale step, instruction at divide by one and two.
  task automatic t_timer();
    logic [6:0] ctl [6];
    int         dv [6];
    ctl = '{7'h01, 7'h09, 7'h03, 7'h0b, 7'h13, 7'h1b};
    dv  = '{4, 8, 1, 2, 4, 8};
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CTRL, 32'h0);
      set_cnt(16'h0000);
      wr(OFF_CTRL, {25'h0, ctl[i]});
      repeat (64) @(posedge clk);
      wr(OFF_CTRL, 32'h0);
      get_cnt(v);
      chk_rng(v, 64 / dv[i] - 1, 68 / dv[i] + 1);
    end
    $display("test timer done");
  endtask : t_timer

  // Rollover, sticky flag, mask and read-to-clear.
  task automatic t_ovf();
    wr(OFF_MASK, 32'h0);
    set_cnt(16'hfffd);
    wr(OFF_CTRL, 32'h3);
    repeat (8) @(posedge clk);
    wr(OFF_CTRL, 32'h0);
    chk({31'h0, irq}, 32'h0);
    get_cnt(v);
    repeat (20) @(posedge clk);
    get_cnt(r[15:0]);
    chk({16'h0, r[15:0]}, {16'h0, v});
    wr(OFF_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(OFF_STAT, 1'b0, 32'h0, r);
    chk(r, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    bus(OFF_STAT, 1'b0, 32'h0, r);
    chk(r, 32'h0);
    $display("test overflow done");
  endtask : t_ovf

  // Gate enabled active high, then active low: the inactive level holds, the active one counts.
  task automatic t_gate();
    wr(OFF_GATE, 32'h3);
    set_cnt(16'h0000);
    wr(OFF_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    wr(OFF_CTRL, 32'h0);
    get_cnt(v);
    chk({16'h0, v}, 32'h0);
    gate_in <= 1'b1;
    repeat (10) @(posedge clk);
    wr(OFF_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    wr(OFF_CTRL, 32'h0);
    get_cnt(v);
    chk_rng(v, 39, 45);
    wr(OFF_GATE, 32'h1);
    bus(OFF_GATE, 1'b0, 32'h0, r);
    chk(r, 32'h5);
    set_cnt(16'h0000);
    wr(OFF_CTRL, 32'h3);
    repeat (20) @(posedge clk);
    wr(OFF_CTRL, 32'h0);
    get_cnt(v);
    chk({16'h0, v}, 32'h0);
    gate_in <= 1'b0;
    repeat (10) @(posedge clk);
    wr(OFF_CTRL, 32'h3);
    repeat (20) @(posedge clk);
    wr(OFF_CTRL, 32'h0);
    get_cnt(v);
    chk_rng(v, 19, 25);
    wr(OFF_GATE, 32'h0);
    $display("test gate done");
  endtask : t_gate

  // External sources, sync and async, awake and asleep, then the system source asleep; first edge is not counted.
  task automatic t_ext();
    logic [6:0] ctl [5];
    logic       sel [5];
    logic       slp [5];
    int         ex [5];
    ctl = '{7'h05, 7'h07, 7'h45, 7'h05, 7'h03};
    sel = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    slp = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    ex  = '{4, 4, 4, 0, 0};
    for (int i = 0; i < 5; i++) begin
      sleep_mode <= slp[i];
      wr(OFF_CTRL, 32'h0);
      set_cnt(16'h0000);
      wr(OFF_CTRL, {25'h0, ctl[i]});
      u_src.pulses(sel[i], 5);
      repeat (12) @(posedge clk);
      wr(OFF_CTRL, 32'h0);
      get_cnt(v);
      chk({16'h0, v}, ex[i]);
    end
    sleep_mode <= 1'b0;
    $display("test external done");
  endtask : t_ext

  // Crystal start-up check in sleep: preset FC00 and wait for the flag.
  task automatic t_xtal();
    wr(OFF_MASK, 32'h1);
    set_cnt(16'hfc00);
    bus(OFF_STAT, 1'b0, 32'h0, r);
    sleep_mode <= 1'b1;
    wr(OFF_CTRL, 32'h65);
    repeat (20000) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    repeat (1000) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    sleep_mode <= 1'b0;
    wr(OFF_CTRL, 32'h0);
    bus(OFF_STAT, 1'b0, 32'h0, r);
    chk(r, 32'h1);
    $display("test crystal done");
  endtask : t_xtal

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////
  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_timer();
    t_ovf();
    t_gate();
    t_ext();
    t_xtal();
    finish_test();
  end
endmodule : test_gstm_timer
